// >>> logic/opfs_top.sv
// opfs_top: function and polarity select for the shutdown/fault pin,
// the receiver rate/general output pin and the loss/transmit rate pin.
// assumes: one core clock; pins and comparator arrive asynchronously;
// internal fault sources come from logic on core_clk.
//
// Overview of operation
// - config three bit 2 low makes pin twelve the shutdown output, else fault input.
// - shutdown output asserts on fault only while config four bit 7 is low.
// - in fault input mode, external fault is ORed with internal faults into tx fault.
// - pin twelve active level is set by config three bit 3, high for active low.
// - config three bit 4 low makes pin twenty-three an open-drain rx rate output.
// - rx rate output is soft rx rate bit OR rx rate pin.
// - config three bit 4 high makes pin twenty-three a general output from config bits.
// - config six bit 2 low makes pin twenty-four an open-drain receive-loss output.
// - config six bit 3 picks low or high level for normal receive operation.
// - loss indication clears once received power is above the loss threshold.
// - loss status bit follows the real level seen on pin twenty-four.
// - config six bit 2 high makes pin twenty-four tx rate output, soft bit OR pin.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
module opfs_top
    import opfs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // fault sources and analog comparator
    input wire logic internal_fault,
    input wire logic rx_below_threshold,
    output logic tx_fault_out,
    // host rate select inputs
    input wire logic rx_rate_pin,
    input wire logic tx_rate_pin,
    // pin twelve: laser_shutdown_out / external_fault_in
    input wire logic pin12_in,
    output logic pin12_out,
    output logic pin12_oe_n,
    // pin twenty-three: rx_rate_select_out / general_output
    output logic pin23_out,
    output logic pin23_oe_n,
    // pin twenty-four: rx_signal_loss_out / tx_rate_select_out
    input wire logic pin24_in,
    output logic pin24_out,
    output logic pin24_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] oem_config_three_r;
    logic [7:0] oem_config_four_r;
    logic [7:0] oem_config_six_r;
    logic [7:0] soft_ctrl_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] sync_q;

    // decoded functions
    logic fault_in_mode;
    logic laser_shutdown_out_pol;
    logic ext_fault;
    logic laser_shutdown_out_active;
    logic pin12_level;
    logic rx_rate_level;
    logic pin23_level;
    logic pin23_drive_high;
    logic loss_active;
    logic loss_level;
    logic tx_rate_level;
    logic pin24_level;
    logic loss_status_bit;
    logic tx_fault_nxt;
    logic [7:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // synchronise every input from outside the clock domain
    assign async_in[SY_PIN12] = pin12_in;
    assign async_in[SY_PIN24] = pin24_in;
    assign async_in[SY_RX_RATE] = rx_rate_pin;
    assign async_in[SY_TX_RATE] = tx_rate_pin;
    assign async_in[SY_RX_BELOW] = rx_below_threshold;

    opfs_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .d(async_in),
        .q(sync_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // configuration register writes
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            oem_config_three_r <= RST_OEM_CONFIG_THREE;
            oem_config_four_r <= RST_OEM_CONFIG_FOUR;
            oem_config_six_r <= RST_OEM_CONFIG_SIX;
            soft_ctrl_r <= RST_SOFT_CTRL;
        end else if (reg_write) begin
            unique case (reg_addr)
                OFS_OEM_CONFIG_THREE: oem_config_three_r <= reg_wdata;
                OFS_OEM_CONFIG_FOUR: oem_config_four_r <= reg_wdata;
                OFS_OEM_CONFIG_SIX: oem_config_six_r <= reg_wdata;
                OFS_SOFT_CTRL: soft_ctrl_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin twelve function and polarity
    assign fault_in_mode = oem_config_three_r[CFG3_FAULT_IN_SEL];
    assign laser_shutdown_out_pol = oem_config_three_r[CFG3_LASER_SHUTDOWN_OUT_POL];
    // polarity bit high means the pin is active low
    assign ext_fault = fault_in_mode & (sync_q[SY_PIN12] ^ laser_shutdown_out_pol);
    // fault asserts shutdown only while the inhibit bit is clear
    assign laser_shutdown_out_active = internal_fault & ~oem_config_four_r[CFG4_FAULT_NO_LASER_SHUTDOWN_OUT];
    assign pin12_level = laser_shutdown_out_active ^ laser_shutdown_out_pol;
    // tx fault from internal sources plus the external input
    assign tx_fault_nxt = internal_fault | ext_fault;

    ////////////////////////////////////////////////////////////////////////
    // pin twenty-three function
    assign rx_rate_level = soft_ctrl_r[SOFT_RX_RATE] | sync_q[SY_RX_RATE];
    assign pin23_level = oem_config_three_r[CFG3_GPO_SEL] ?
        oem_config_three_r[CFG3_GPO_LEVEL] : rx_rate_level;
    // rate output is open drain only; general output may be push-pull
    assign pin23_drive_high = oem_config_three_r[CFG3_GPO_SEL] &
        oem_config_three_r[CFG3_GPO_PUSH_PULL];

    ////////////////////////////////////////////////////////////////////////
    // pin twenty-four function
    // loss while power is below threshold, cleared once above it
    assign loss_active = sync_q[SY_RX_BELOW];
    assign loss_level = loss_active ^ oem_config_six_r[CFG6_LOSS_POL];
    assign tx_rate_level = soft_ctrl_r[SOFT_TX_RATE] | sync_q[SY_TX_RATE];
    assign pin24_level = oem_config_six_r[CFG6_TX_RATE_SEL] ? tx_rate_level : loss_level;
    // status follows the wire itself, so external wired-or drivers show
    assign loss_status_bit = sync_q[SY_PIN24] ^ oem_config_six_r[CFG6_LOSS_POL];

    ////////////////////////////////////////////////////////////////////////
    // pin drivers, registered from current configuration
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin12_out <= 1'b0;
            pin12_oe_n <= 1'b1;
            pin23_out <= 1'b0;
            pin23_oe_n <= 1'b1;
            pin24_out <= 1'b0;
            pin24_oe_n <= 1'b1;
        end else begin
            // shutdown output is push-pull; fault input mode releases the pin
            pin12_out <= pin12_level;
            pin12_oe_n <= fault_in_mode;
            // open drain pulls low only, push-pull drives both levels
            pin23_out <= pin23_level;
            pin23_oe_n <= pin23_level & ~pin23_drive_high;
            // both functions of pin twenty-four are open drain
            pin24_out <= 1'b0;
            pin24_oe_n <= pin24_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter fault output
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tx_fault_out <= 1'b0;
        end else begin
            tx_fault_out <= tx_fault_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word and read data
    always_comb begin
        status_word = 8'h00;
        status_word[STS_LOSS] = loss_status_bit;
        status_word[STS_TX_FAULT] = tx_fault_nxt;
        status_word[STS_RX_RATE_PIN] = sync_q[SY_RX_RATE];
        status_word[STS_TX_RATE_PIN] = sync_q[SY_TX_RATE];
        status_word[STS_EXT_FAULT] = ext_fault;
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            OFS_OEM_CONFIG_THREE: rdata_nxt = oem_config_three_r;
            OFS_OEM_CONFIG_FOUR: rdata_nxt = oem_config_four_r;
            OFS_OEM_CONFIG_SIX: rdata_nxt = oem_config_six_r;
            OFS_SOFT_CTRL: rdata_nxt = soft_ctrl_r;
            OFS_PIN_STATUS: rdata_nxt = status_word;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// >>> logic/opfs_pkg.sv
// opfs_pkg: register offsets, field positions and reset values for the
// pin function select block.
// assumes: an 8-bit register port with a 4-bit word address.
package opfs_pkg;

    // register port widths
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [3:0] OFS_OEM_CONFIG_THREE = 4'h0;
    localparam logic [3:0] OFS_OEM_CONFIG_FOUR = 4'h1;
    localparam logic [3:0] OFS_OEM_CONFIG_SIX = 4'h2;
    localparam logic [3:0] OFS_SOFT_CTRL = 4'h3;
    localparam logic [3:0] OFS_PIN_STATUS = 4'h4;

    // reset values
    localparam logic [7:0] RST_OEM_CONFIG_THREE = 8'h00;
    localparam logic [7:0] RST_OEM_CONFIG_FOUR = 8'h00;
    localparam logic [7:0] RST_OEM_CONFIG_SIX = 8'h00;
    localparam logic [7:0] RST_SOFT_CTRL = 8'h00;

    // oem_config_three fields
    localparam int unsigned CFG3_FAULT_IN_SEL = 2;
    localparam int unsigned CFG3_LASER_SHUTDOWN_OUT_POL = 3;
    localparam int unsigned CFG3_GPO_SEL = 4;
    localparam int unsigned CFG3_GPO_LEVEL = 5;
    localparam int unsigned CFG3_GPO_PUSH_PULL = 6;

    // oem_config_four fields
    localparam int unsigned CFG4_FAULT_NO_LASER_SHUTDOWN_OUT = 7;

    // oem_config_six fields
    localparam int unsigned CFG6_TX_RATE_SEL = 2;
    localparam int unsigned CFG6_LOSS_POL = 3;

    // soft control fields
    localparam int unsigned SOFT_RX_RATE = 0;
    localparam int unsigned SOFT_TX_RATE = 1;

    // status fields
    localparam int unsigned STS_LOSS = 0;
    localparam int unsigned STS_TX_FAULT = 1;
    localparam int unsigned STS_RX_RATE_PIN = 2;
    localparam int unsigned STS_TX_RATE_PIN = 3;
    localparam int unsigned STS_EXT_FAULT = 4;

    // synchroniser bit positions
    localparam int unsigned SYNC_W = 5;
    localparam int unsigned SY_PIN12 = 0;
    localparam int unsigned SY_PIN24 = 1;
    localparam int unsigned SY_RX_RATE = 2;
    localparam int unsigned SY_TX_RATE = 3;
    localparam int unsigned SY_RX_BELOW = 4;

endpackage

// >>> logic/opfs_sync.sv
// opfs_sync: two flip-flop synchroniser, one stage pair per bit.
// assumes: inputs are asynchronous levels; only the second stage is read.
`timescale 1ns/100ps
module opfs_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic meta_r;
            // two stages per bit
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    meta_r <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    q[i] <= meta_r;
                end
            end
        end
    endgenerate

endmodule

// >>> dv/opfs_properties.sv
// opfs_properties: level and timing checks on the opfs_top ports.
// assumes: the config registers are shadowed here from register port writes.
`timescale 1ns/100ps
module opfs_properties
    import opfs_pkg::*;
(
    // clock, reset and register port
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    // faults and pins
    input wire logic internal_fault,
    input wire logic tx_fault_out,
    input wire logic pin12_out,
    input wire logic pin12_oe_n,
    input wire logic pin23_out,
    input wire logic pin23_oe_n,
    input wire logic pin24_out,
    input wire logic pin24_oe_n
);
    logic [7:0] cfg3_r, cfg4_r, cfg6_r, soft_r;
    logic [1:0] quiet_r;
    logic calm;
    ////////////////////////////////////////////////////////////////
    // shadow the config and count quiet cycles since the last write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            {cfg3_r, cfg4_r, cfg6_r, soft_r} <= '0;
            quiet_r <= 2'h0;
        end else begin
            quiet_r <= reg_write ? 2'h0 : (calm ? quiet_r : quiet_r + 2'h1);
            if (reg_write && reg_addr == OFS_OEM_CONFIG_THREE) cfg3_r <= reg_wdata;
            if (reg_write && reg_addr == OFS_OEM_CONFIG_FOUR) cfg4_r <= reg_wdata;
            if (reg_write && reg_addr == OFS_OEM_CONFIG_SIX) cfg6_r <= reg_wdata;
            if (reg_write && reg_addr == OFS_SOFT_CTRL) soft_r <= reg_wdata;
        end
    end
    // config settled long enough for the registered pins to follow
    assign calm = (quiet_r == 2'h3);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    a_laser_shutdown_out_level: assert property (calm && !cfg3_r[CFG3_FAULT_IN_SEL] |-> !pin12_oe_n &&
        pin12_out == (($past(internal_fault) & !cfg4_r[CFG4_FAULT_NO_LASER_SHUTDOWN_OUT]) ^ cfg3_r[CFG3_LASER_SHUTDOWN_OUT_POL]))
        else $error("shutdown level wrong");
    a_fault_release: assert property (calm && cfg3_r[CFG3_FAULT_IN_SEL] |-> pin12_oe_n)
        else $error("pin12 driven in input mode");
    a_tx_fault_int: assert property (calm && cfg3_r[CFG3_FAULT_IN_SEL] && $past(internal_fault) |-> tx_fault_out)
        else $error("internal fault lost");
    a_rx_rate_od: assert property (calm && !cfg3_r[CFG3_GPO_SEL] |-> pin23_oe_n || !pin23_out)
        else $error("rx rate not open drain");
    a_rx_soft_rate: assert property (calm && !cfg3_r[CFG3_GPO_SEL] && soft_r[SOFT_RX_RATE] |-> pin23_oe_n)
        else $error("soft rx rate ignored");
    a_gpo_level: assert property (calm && cfg3_r[CFG3_GPO_SEL] |-> (pin23_oe_n ?
        cfg3_r[CFG3_GPO_LEVEL] && !cfg3_r[CFG3_GPO_PUSH_PULL] : pin23_out == cfg3_r[CFG3_GPO_LEVEL]))
        else $error("general output wrong");
    a_loss_od: assert property (pin24_oe_n || !pin24_out)
        else $error("pin24 driven high");
    a_tx_soft_rate: assert property (calm && cfg6_r[CFG6_TX_RATE_SEL] && soft_r[SOFT_TX_RATE] |-> pin24_oe_n)
        else $error("soft tx rate ignored");
    a_cfg_readback: assert property ($past(reg_read) && $past(reg_addr) == OFS_OEM_CONFIG_THREE |->
        reg_rdata == $past(cfg3_r)) else $error("config readback wrong");
    c_laser_shutdown_out_on: cover property (calm && !pin12_oe_n && pin12_out);
    c_ext_fault: cover property (calm && cfg3_r[CFG3_FAULT_IN_SEL] && tx_fault_out && !internal_fault);
    c_gpo_push: cover property (calm && cfg3_r[CFG3_GPO_SEL] && !pin23_oe_n && pin23_out);
endmodule

// >>> dv/opfs_far_side.sv
// opfs_far_side: host and laser driver side of the three pins.
// assumes: pull-ups on pins twenty-three and twenty-four; host drives pin twelve and may pull pin twenty-four low.
`timescale 1ns/100ps
module opfs_far_side (
    // pins from the block
    input wire logic pin12_out,
    input wire logic pin12_oe_n,
    input wire logic pin23_out,
    input wire logic pin23_oe_n,
    input wire logic pin24_out,
    input wire logic pin24_oe_n,
    // host side controls
    input wire logic ext_fault_level,
    input wire logic ext_loss_pull,
    // resolved wire levels
    output logic pin12_wire,
    output logic pin23_wire,
    output logic pin24_wire
);
    // host drives pin twelve only while the block has let it go
    assign pin12_wire = pin12_oe_n ? ext_fault_level : pin12_out;
    // released lines rest high on their pull-ups; pin24 is wire-ORed low
    assign pin23_wire = pin23_oe_n ? 1'b1 : pin23_out;
    assign pin24_wire = (ext_loss_pull || (!pin24_oe_n && !pin24_out)) ? 1'b0 : 1'b1;
endmodule

// >>> dv/opfs_test.sv
// opfs_test: self-checking bench for opfs_top with the far side model.
// assumes: 250 MHz clock, reset held ten cycles.
`timescale 1ns/100ps
module opfs_test import opfs_pkg::*;;
    logic core_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, internal_fault = 1'b0;
    logic rx_below_threshold = 1'b0, rx_rate_pin = 1'b0, tx_rate_pin = 1'b0, ext_fault_level = 1'b0;
    logic ext_loss_pull = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
    logic tx_fault_out, pin12_out, pin12_oe_n, pin23_out, pin23_oe_n, pin24_out, pin24_oe_n;
    logic pin12_wire, pin23_wire, pin24_wire;
    int fail_count = 0, total_checks = 0, cycles = 0;
    // clock
    always #2 core_clk = ~core_clk;
    opfs_top opfs_top_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .internal_fault, .rx_below_threshold, .tx_fault_out, .rx_rate_pin, .tx_rate_pin, .pin12_in(pin12_wire),
        .pin12_out, .pin12_oe_n, .pin23_out, .pin23_oe_n, .pin24_in(pin24_wire), .pin24_out, .pin24_oe_n);
    opfs_far_side opfs_far_side_i (.pin12_out, .pin12_oe_n, .pin23_out, .pin23_oe_n, .pin24_out, .pin24_oe_n,
        .ext_fault_level, .ext_loss_pull, .pin12_wire, .pin23_wire, .pin24_wire);
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask
    task automatic settle;
        repeat (6) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        settle();
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    ////////////////////////////////////////////////////////////////
    // reset values, then an ignored write to an unmapped place
    task automatic t_reset;
        for (int i = 0; i < 5; i++) begin
            rd(i == 4 ? 4'hf : 4'(i));
            chk("reset value", v, 8'h00);
        end
        wr(4'hf, 8'hff);
        rd(4'hf);
        chk("unmapped", v, 8'h00);
    endtask
    // shutdown output over both polarities and the fault mask
    task automatic t_shutdown;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_OEM_CONFIG_THREE, {4'h0, i[0], 3'h0});
            wr(OFS_OEM_CONFIG_FOUR, {i[1], 7'h00});
            @(posedge core_clk);
            internal_fault <= 1'b1;
            settle();
            chk("shutdown on fault", pin12_wire, !i[1] ^ i[0]);
            chk("shutdown drive", pin12_oe_n, 1'b0);
            @(posedge core_clk);
            internal_fault <= 1'b0;
            settle();
            chk("shutdown idle", pin12_wire, i[0]);
        end
    endtask
    // external fault input ORed into tx fault
    task automatic t_fault_in;
        wr(OFS_OEM_CONFIG_FOUR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(OFS_OEM_CONFIG_THREE, {4'h0, i[0], 3'h4});
            @(posedge core_clk);
            ext_fault_level <= i[1];
            internal_fault <= i[2];
            settle();
            chk("tx fault", tx_fault_out, (i[1] ^ i[0]) | i[2]);
            chk("fault pin released", pin12_oe_n, 1'b1);
        end
    endtask
    // pin23 as rate select, then as general output
    task automatic t_pin23;
        wr(OFS_OEM_CONFIG_THREE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SOFT_CTRL, {7'h00, i[0]});
            @(posedge core_clk);
            rx_rate_pin <= i[1];
            settle();
            chk("rx rate pin", pin23_wire, i[0] | i[1]);
        end
        for (int j = 0; j < 4; j++) begin
            wr(OFS_OEM_CONFIG_THREE, {1'b0, j[1], j[0], 5'h10});
            chk("general out", pin23_wire, j[0]);
            chk("general out drive", pin23_oe_n, !j[1] & j[0]);
        end
    endtask
    // pin24 as loss output, wired-OR, then as tx rate select
    task automatic t_pin24;
        for (int i = 0; i < 4; i++) begin
            wr(OFS_OEM_CONFIG_SIX, {4'h0, i[0], 3'h0});
            @(posedge core_clk);
            rx_below_threshold <= i[1];
            settle();
            chk("loss pin", pin24_wire, i[1] ^ i[0]);
            rd(OFS_PIN_STATUS);
            chk("loss bit", v[STS_LOSS], i[1]);
        end
        @(posedge core_clk);
        rx_below_threshold <= 1'b0;
        ext_loss_pull <= 1'b1;
        settle();
        rd(OFS_PIN_STATUS);
        chk("loss bit external", v[STS_LOSS], 1'b1);
        wr(OFS_OEM_CONFIG_SIX, 8'h04);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_SOFT_CTRL, {6'h00, i[0], 1'b0});
            @(posedge core_clk);
            tx_rate_pin <= i[1];
            ext_loss_pull <= 1'b0;
            settle();
            chk("tx rate pin", pin24_wire, i[0] | i[1]);
        end
    endtask
    // cut a hung run short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_shutdown();
        t_fault_in();
        t_pin23();
        t_pin24();
        conclude();
    end
endmodule
bind opfs_top opfs_properties opfs_properties_i (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .internal_fault(internal_fault), .tx_fault_out(tx_fault_out), .pin12_out(pin12_out), .pin12_oe_n(pin12_oe_n),
    .pin23_out(pin23_out), .pin23_oe_n(pin23_oe_n), .pin24_out(pin24_out), .pin24_oe_n(pin24_oe_n));
